//--- verilog/loc_pkg.sv
package loc_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam logic [13:0] TICK_DIV_MAX = 14'(TICK_CYC - 1);
  localparam logic [15:0] ON_DELAY_MAX_MS = 16'hEA60;
  localparam logic [15:0] HOLD_MAX_MS = 16'h270F;
  localparam logic [15:0] ON_DELAY_RST = 16'h0000;
  localparam logic [15:0] HOLD_RST = 16'h0000;
  localparam logic POLARITY_RST = 1'b0;
  // register byte offsets
  localparam logic [11:0] OFS_C_SEL = 12'h000;
  localparam logic [11:0] OFS_C_DLY = 12'h004;
  localparam logic [11:0] OFS_C_HLD = 12'h008;
  localparam logic [11:0] OFS_C_POL = 12'h00C;
  localparam logic [11:0] OFS_D_SEL = 12'h010;
  localparam logic [11:0] OFS_D_DLY = 12'h014;
  localparam logic [11:0] OFS_D_HLD = 12'h018;
  localparam logic [11:0] OFS_D_POL = 12'h01C;
  localparam logic [11:0] OFS_STATUS = 12'h020;
  localparam int unsigned SEL_W = 5;
  localparam logic [4:0] SEL_NONE = 5'h00;
  localparam logic [4:0] SEL_NO_FAULT = 5'h01;
  localparam logic [4:0] SEL_OUT_CONT = 5'h02;
  localparam logic [4:0] SEL_DC_PRECH = 5'h03;
  localparam logic [4:0] SEL_LINE_CONT = 5'h04;
  localparam int unsigned NUM_COND = 32;
  typedef struct packed {
    logic [4:0] sel;
    logic [15:0] on_delay;
    logic [15:0] hold;
    logic active_low;
  } loc_cfg_t;
  localparam loc_cfg_t CFG_RST = '{SEL_NONE, ON_DELAY_RST, HOLD_RST, POLARITY_RST};
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_ON_WAIT = 4'h2,
    ST_ON = 4'h4,
    ST_HOLD_WAIT = 4'h8
  } loc_state_t;
endpackage

//--- verilog/loc_conditioner.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module loc_conditioner
  import loc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CARD_FITTED,
  input wire logic [NUM_COND-1:0] COND_IN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic COND_OUTPUT_C,
  output logic COND_OUTPUT_D
);
  // forced-zero / locked classes of assignment
  function automatic logic no_delay(input logic [4:0] s);
    return s == SEL_NO_FAULT || s == SEL_OUT_CONT || s == SEL_DC_PRECH || s == SEL_LINE_CONT;
  endfunction
  function automatic logic no_hold(input logic [4:0] s);
    return s == SEL_NO_FAULT || s == SEL_DC_PRECH || s == SEL_LINE_CONT;
  endfunction
  // polarity lock set happens to match the hold set, but is kept apart for clarity
  function automatic logic pol_locked(input logic [4:0] s);
    return s == SEL_NO_FAULT || s == SEL_DC_PRECH || s == SEL_LINE_CONT;
  endfunction
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    return (v > mx) ? mx : v;
  endfunction

  logic rst_s1_r, rst_s2_r;
  wire rst_n_i = rst_s2_r;
  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // 1 ms tick enable
  logic [13:0] div_r;
  logic tick_r;
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 14'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == TICK_DIV_MAX);
      div_r <= (div_r == TICK_DIV_MAX) ? 14'h0000 : div_r + 14'h0001;
    end
  end

  // apb phase decode; zero wait states, so the answer is always ready in the
  // first access cycle and a master never waits longer than that
  wire setup = PSEL && !PENABLE;
  wire wr = PSEL && PENABLE && PWRITE;
  wire rd_setup = setup && !PWRITE;

  // address decode: one aligned word per register, nothing above the status word
  wire [3:0] idx = PADDR[5:2];
  wire aligned = PADDR[1:0] == 2'b00;
  wire in_page = PADDR[11:6] == 6'h00;
  wire is_status = idx == OFS_STATUS[5:2];
  wire hit = aligned && in_page && idx <= OFS_STATUS[5:2];

  // the eight setting registers vanish with the card; status stays readable so
  // software can always find out whether the card is there
  wire card_reg = idx < OFS_STATUS[5:2];
  wire ok = hit && (!card_reg || CARD_FITTED);
  wire wr_ok = wr && ok;

  // settings of both channels, gathered here for the read mux
  loc_cfg_t cfg_q [2];
  wire [1:0] out_q;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : ch
      // register index of this channel's selection word
      localparam logic [3:0] B = 4'(g * 4);
      loc_cfg_t cfg_r;
      wire [4:0] wsel = PWDATA[4:0];

      // per-field write strobes of this channel
      wire wr_sel = wr_ok && idx == B;
      wire wr_dly = wr_ok && idx == B + 4'h1;
      wire wr_hld = wr_ok && idx == B + 4'h2;
      wire wr_pol = wr_ok && idx == B + 4'h3;

      // a locking assignment refuses later writes to its forced fields; the
      // write is accepted on the bus but silently has no effect
      wire dly_free = !no_delay(cfg_r.sel);
      wire hld_free = !no_hold(cfg_r.sel);
      wire pol_free = !pol_locked(cfg_r.sel);

      // out-of-range values are clamped rather than refused, so a too-long
      // setting still gives the longest legal time
      wire [15:0] dly_wr = clamp(PWDATA[15:0], ON_DELAY_MAX_MS);
      wire [15:0] hld_wr = clamp(PWDATA[15:0], HOLD_MAX_MS);

      // setting registers; choosing a locking assignment zeroes what it forces
      always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
          cfg_r <= CFG_RST;
        end else if (wr_sel) begin
          cfg_r.sel <= wsel;
          if (no_delay(wsel)) cfg_r.on_delay <= 16'h0000;
          if (no_hold(wsel)) cfg_r.hold <= 16'h0000;
          if (pol_locked(wsel)) cfg_r.active_low <= 1'b0;
        end else if (wr_dly && dly_free) begin
          cfg_r.on_delay <= dly_wr;
        end else if (wr_hld && hld_free) begin
          cfg_r.hold <= hld_wr;
        end else if (wr_pol && pol_free) begin
          cfg_r.active_low <= PWDATA[0];
        end
      end
      assign cfg_q[g] = cfg_r;

      // conditioned information: selection none never asserts, and without the
      // card the channel does not exist at all
      wire sel_used = cfg_r.sel != SEL_NONE;
      wire info = sel_used && COND_IN[cfg_r.sel] && CARD_FITTED;

      loc_state_t st_r, st_nxt;
      logic [15:0] cnt_r, cnt_nxt;

      // delay / hold sequencer; an early reversal drops the pending change.
      // the tick phase is free running, so each wait is short by up to one tick
      always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        case (st_r)
          ST_OFF: begin
            if (info) begin
              st_nxt = (cfg_r.on_delay == 16'h0000) ? ST_ON : ST_ON_WAIT;
              cnt_nxt = cfg_r.on_delay;
            end
          end
          ST_ON_WAIT: begin
            if (!info) begin
              st_nxt = ST_OFF;
            end else if (tick_r) begin
              if (cnt_r <= 16'h0001) st_nxt = ST_ON;
              cnt_nxt = cnt_r - 16'h0001;
            end
          end
          ST_ON: begin
            if (!info) begin
              st_nxt = (cfg_r.hold == 16'h0000) ? ST_OFF : ST_HOLD_WAIT;
              cnt_nxt = cfg_r.hold;
            end
          end
          ST_HOLD_WAIT: begin
            if (info) begin
              st_nxt = ST_ON;
            end else if (tick_r) begin
              if (cnt_r <= 16'h0001) st_nxt = ST_OFF;
              cnt_nxt = cnt_r - 16'h0001;
            end
          end
          default: begin
            st_nxt = ST_OFF;
          end
        endcase
      end

      // the output counts as active through the hold time as well
      wire on = (st_r == ST_ON) || (st_r == ST_HOLD_WAIT);
      // polarity flips the pin level, card absence forces it low
      wire pin_lvl = CARD_FITTED && (on ^ cfg_r.active_low);
      logic out_r;

      // sequencer state and the pin flop; the pin comes straight from out_r
      always_ff @(posedge CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
          st_r <= ST_OFF;
          cnt_r <= 16'h0000;
          out_r <= 1'b0;
        end else begin
          st_r <= st_nxt;
          cnt_r <= cnt_nxt;
          out_r <= pin_lvl;
        end
      end
      assign out_q[g] = out_r;
    end
  endgenerate

  // read mux; status shows live output state and card presence
  wire [1:0] fld = idx[1:0];
  loc_cfg_t rc;
  assign rc = cfg_q[idx[2]];
  wire [31:0] stat_word = {29'h0, CARD_FITTED, out_q};
  wire [31:0] sel_word = {27'h0, rc.sel};
  wire [31:0] dly_word = {16'h0, rc.on_delay};
  wire [31:0] hld_word = {16'h0, rc.hold};
  wire [31:0] pol_word = {31'h0, rc.active_low};
  wire [31:0] cfg_word = fld == 2'h0 ? sel_word : fld == 2'h1 ? dly_word :
    fld == 2'h2 ? hld_word : pol_word;
  wire [31:0] rmux = is_status ? stat_word : cfg_word;
  // a refused read returns zero so nothing leaks from an absent card
  wire [31:0] rd_word = ok ? rmux : 32'h00000000;

  // bus answer flops; they are loaded in setup and stand for the access cycle
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !ok;
      if (rd_setup) PRDATA <= rd_word;
    end
  end

  // the pins come straight from the per-channel output flops
  assign COND_OUTPUT_C = out_q[0];
  assign COND_OUTPUT_D = out_q[1];
endmodule

//--- verif/loc_relay.sv
`timescale 1ns/1ps
// contactor on the output pin: contacts follow the coil one clock late
module loc_relay (
  input wire logic CLK,
  input wire logic COIL,
  output logic CLOSED
);
  always_ff @(posedge CLK) begin
    CLOSED <= COIL;
  end
endmodule

//--- verif/loc_props.sv
`timescale 1ns/1ps
module loc_props
  import loc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CARD_FITTED,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic COND_OUTPUT_C,
  input wire logic COND_OUTPUT_D
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // a completing access; zero wait states is the promised answer time
  wire acc = PSEL && PENABLE && PREADY;
  chk_card_off_c: assert property (!CARD_FITTED [*3] |-> !COND_OUTPUT_C)
    else $error("out c active without card");
  chk_card_off_d: assert property (!CARD_FITTED [*3] |-> !COND_OUTPUT_D)
    else $error("out d active without card");
  chk_card_err: assert property (acc && !CARD_FITTED && PADDR < OFS_STATUS |-> PSLVERR)
    else $error("card register answered without card");
  chk_mapped_ok: assert property (acc && CARD_FITTED && PADDR <= OFS_STATUS |-> !PSLVERR)
    else $error("mapped register refused");
  chk_unmapped_err: assert property (acc && PADDR > OFS_STATUS |-> PSLVERR)
    else $error("unmapped access not refused");
  chk_card_stat: assert property (acc && !PWRITE && PADDR == OFS_STATUS
    |-> PRDATA[2] == $past(CARD_FITTED))
    else $error("status card bit wrong");
  chk_ready_access: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in first access cycle");
  chk_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
endmodule
bind loc_conditioner loc_props u_props(.CLK, .RST_N, .CARD_FITTED, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PRDATA, .PREADY, .PSLVERR, .COND_OUTPUT_C, .COND_OUTPUT_D);

//--- verif/loc_conditioner_test.sv
`timescale 1ns/1ps
module loc_conditioner_test import loc_pkg::*;;
  logic clk = 0, rst_n = 0, card = 1, psel = 0, pen = 0, pwr = 0, er, prdy, perr, o_c, o_d, cl;
  logic [31:0] cond = '0, pwd = '0, rd, prd;
  logic [11:0] pa = '0;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  loc_conditioner uut(.CLK(clk), .RST_N(rst_n), .CARD_FITTED(card), .COND_IN(cond), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .COND_OUTPUT_C(o_c), .COND_OUTPUT_D(o_d));
  loc_relay relay(.CLK(clk), .COIL(o_c), .CLOSED(cl));
  task summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %0t got %h want %h", $time, s, e);
    end
  endtask
  // apb cycle; request held until ready is seen at an edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do @(posedge clk); while (prdy !== 1'h1);
    rd = prd;
    er = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  // hang guard, well above the longest timed sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      summarize;
    end
  end
  // 1 ms is 10000 clocks; tick phase takes up to one ms off each wait
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    wt(4);
    for (int i = 0; i < 4; i++) begin
      xfer(1'h0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    xfer(1'h1, OFS_C_DLY, 32'h2);
    xfer(1'h1, OFS_C_HLD, 32'h2);
    xfer(1'h1, OFS_C_SEL, 32'h5);
    cond <= 32'h20;
    wt(5000);
    chk(32'(cl), 32'h0);
    wt(26000);
    chk(32'(cl), 32'h1);
    cond <= 32'h0;
    wt(5000);
    chk(32'(cl), 32'h1);
    cond <= 32'h20;
    wt(21000);
    chk(32'(cl), 32'h1);
    cond <= 32'h0;
    wt(21000);
    chk(32'(cl), 32'h0);
    xfer(1'h1, OFS_C_POL, 32'h1);
    wt(3);
    chk(32'(o_c), 32'h1);
    xfer(1'h0, OFS_C_POL, 32'h0);
    chk(rd, 32'h1);
    xfer(1'h1, OFS_C_SEL, 32'h3);
    xfer(1'h1, OFS_C_POL, 32'h1);
    for (int i = 1; i < 4; i++) begin
      xfer(1'h0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    cond <= '1;
    wt(3);
    chk(32'(o_c), 32'h1);
    chk(32'(o_d), 32'h0);
    xfer(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h5);
    xfer(1'h1, OFS_D_SEL, 32'h5);
    wt(3);
    chk(32'(o_d), 32'h1);
    xfer(1'h0, 12'h024, 32'h0);
    chk(32'(er), 32'h1);
    card <= 1'h0;
    xfer(1'h0, OFS_D_SEL, 32'h0);
    chk(32'(er), 32'h1);
    chk(32'(o_c), 32'h0);
    chk(32'(o_d), 32'h0);
    xfer(1'h0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h0);
    summarize;
  end
endmodule
